// file: bench/bbp_ctrl_properties.sv
`include "bbp_defines.svh"
`default_nettype none
module bbp_ctrl_properties (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	// pins and stage
	input wire logic hardware_enable_pin,
	input wire bbp_pkg::bbp_stage_t stage,
	// control outputs
	input wire logic [3:0] sink_enable,
	input wire logic boost_gate,
	input wire bbp_pkg::bbp_freq_t boost_freq,
	input wire logic max_duty_half,
	input wire bbp_pkg::bbp_bias_t bias
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] on_run;
	default clocking dc @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// consecutive cycles with the low-side switch on
	always_ff @(posedge aclk) begin
		if (!aresetn || !boost_gate) on_run <= 9'h000;
		else if (on_run != 9'h1FF) on_run <= on_run + 9'h001;
	end
	half_duty_a: assert property ($stable(boost_freq) |-> max_duty_half == (boost_freq == bbp_pkg::BBP_F250K))
		else $error("duty cap flag disagrees with frequency");
	duty_cap_a: assert property (boost_freq == bbp_pkg::BBP_F250K |-> on_run <= 9'(`BBP_PER_250K / 2 + 1))
		else $error("switch on too long at lowest frequency");
	trip_cut_a: assert property ($rose(stage.current_trip) |-> ##[2:5] !boost_gate)
		else $error("switch not cut after current trip");
	ov_stop_a: assert property (stage.boost_overvoltage [*4] |-> !boost_gate)
		else $error("switching during overvoltage");
	shutdown_off_a: assert property (!hardware_enable_pin [*6] |-> sink_enable == 4'h0 && !boost_gate && !bias.pos_on && !bias.neg_on)
		else $error("outputs active in shutdown");
	discharge_off_a: assert property ((bias.pos_on && bias.neg_on) [*2] |-> !bias.pos_discharge && !bias.neg_discharge)
		else $error("discharge while rail on");
	read_answer_a: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	read_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data not held");
	write_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response not held");
	cover property (boost_freq == bbp_pkg::BBP_F250K && boost_gate);
	cover property (stage.current_trip && boost_gate);
	cover property (bias.pos_on && bias.neg_on);
endmodule
bind bbp_ctrl bbp_ctrl_properties chk_u (
	.aclk(aclk), .aresetn(aresetn), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
	.rready(rready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .hardware_enable_pin(hardware_enable_pin),
	.stage(stage), .sink_enable(sink_enable), .boost_gate(boost_gate), .boost_freq(boost_freq),
	.max_duty_half(max_duty_half), .bias(bias)
);
`default_nettype wire

// file: bench/bbp_power_model.sv
`default_nettype none
module bbp_power_model (
	// sink and switch state from the block
	input wire logic [3:0] sink_enable,
	input wire logic boost_gate,
	// faults commanded by the bench
	input wire logic [3:0] open_mask,
	input wire logic [3:0] short_mask,
	input wire logic trip_req,
	input wire logic overload_req,
	// sensed stage
	output var bbp_pkg::bbp_stage_t stage
);
	timeunit 1ns;
	timeprecision 1ps;
	always_comb begin
		stage.sink_over_v = short_mask & sink_enable;
		stage.sink_low_headroom = open_mask & sink_enable;
		stage.boost_overvoltage = |(open_mask & sink_enable);
		stage.current_trip = trip_req & boost_gate;
		stage.pos_rail_overload = overload_req;
	end
endmodule
`default_nettype wire

// file: bench/testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic hardware_enable_pin = 1'b1;
	logic pos_rail_enable_pin = 1'b0;
	logic neg_rail_enable_pin = 1'b0;
	logic [3:0] open_mask = 4'h0;
	logic [3:0] short_mask = 4'h0;
	logic trip_req = 1'b0;
	logic overload_req = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, max_duty_half, boost_gate;
	logic [1:0] bresp, rresp, current_limit_sel;
	logic [31:0] rdata;
	logic [3:0] sink_enable;
	bbp_pkg::bbp_freq_t boost_freq;
	bbp_pkg::bbp_stage_t stage;
	bbp_pkg::bbp_bias_t bias;
	logic [7:0] rails, lo, hi, b;
	logic [31:0] seed = 32'h4BD38CCA;
	logic [31:0] r;
	logic [1:0] bq[$];
	logic [9:0] rq[$];
	int err_total = 0;
	int check_count = 0;
	int i;
	logic [12:0] dflt [14] = '{13'h0228, 13'h038D, 13'h05FF, 13'h0600, 13'h0700, 13'h0800, 13'h0918,
		13'h0A11, 13'h0B00, 13'h0C1E, 13'h0D1E, 13'h0E1E, 13'h1000, 13'h1100};
	assign rails = {4'h0, bias.pos_on, bias.neg_on, bias.pos_discharge, bias.neg_discharge};
	always #10 aclk = ~aclk;
	bbp_ctrl #(.SHORT_QUAL_CYC(20), .FILT0_CYC(4), .FILT1_CYC(8), .FILT2_CYC(12), .FILT3_CYC(16)) dut_u (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .hardware_enable_pin(hardware_enable_pin),
		.pos_rail_enable_pin(pos_rail_enable_pin), .neg_rail_enable_pin(neg_rail_enable_pin), .stage(stage),
		.sink_enable(sink_enable), .boost_gate(boost_gate), .boost_freq(boost_freq),
		.max_duty_half(max_duty_half), .current_limit_sel(current_limit_sel), .bias(bias)
	);
	bbp_power_model model_u (
		.sink_enable(sink_enable), .boost_gate(boost_gate), .open_mask(open_mask), .short_mask(short_mask),
		.trip_req(trip_req), .overload_req(overload_req), .stage(stage)
	);
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] fexp(input logic [7:0] bv, input logic [7:0] l, input logic [7:0] h,
		input logic fx);
		if (l == 8'h00 && h == 8'h00) return fx ? 8'h02 : 8'h01;
		if (bv <= l) return 8'h00;
		return (bv <= h) ? 8'h01 : 8'h02;
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wrap_up();
		if (err_total == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic cmp_bus(input string nm, input logic [9:0] e, input logic [9:0] g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic pin(input string nm, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [4:0] ix, input logic [7:0] d, input logic [1:0] er);
		logic [31:0] x;
		int n;
		x = xs();
		bq.push_back(er);
		@(posedge aclk);
		awaddr <= {5'h00, ix, 2'b00};
		wdata <= {x[31:8], d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		if (n == 40) err_total++;
	endtask
	task automatic rd(input logic [4:0] ix, input logic [9:0] e);
		int n;
		rq.push_back(e);
		@(posedge aclk);
		araddr <= {5'h00, ix, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		if (n == 40) err_total++;
	endtask
	// answers off the bus against the oldest note
	always @(posedge aclk) begin
		if (bvalid && bready) cmp_bus("write resp", {8'h00, bq.pop_front()}, {8'h00, bresp});
		if (rvalid && rready) cmp_bus("read data", rq.pop_front(), {rresp, rdata[7:0]});
	end
	initial begin
		#800000;
		err_total++;
		wrap_up();
	end
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		cyc(6);
		wr(5'h11, 8'h03, 2'b00);
		wr(5'h08, 8'h80, 2'b00);
		cyc(2);
		for (i = 0; i < 14; i++) rd(dflt[i][12:8], {2'b00, dflt[i][7:0]});
		rd(5'h01, 10'h200);
		wr(5'h04, 8'h55, 2'b10);
		hardware_enable_pin <= 1'b0;
		cyc(8);
		wr(5'h11, 8'h02, 2'b00);
		hardware_enable_pin <= 1'b1;
		cyc(6);
		rd(5'h11, 10'h000);
		wstrb <= 4'hE;
		wr(5'h11, 8'h01, 2'b00);
		wstrb <= 4'hF;
		rd(5'h11, 10'h000);
		for (i = 0; i < 4; i++) begin
			wr(5'h11, {6'h2A, 2'(i)}, 2'b00);
			cyc(4);
			pin("limit", 8'(i), {6'h00, current_limit_sel});
		end
		wr(5'h08, 8'h1F, 2'b00);
		for (i = 0; i < 8; i++) begin
			r = xs();
			lo = (i < 2) ? 8'h00 : r[15:8] & 8'h7F;
			hi = (i < 2) ? 8'h00 : r[23:16] | 8'h80;
			b = (i == 2) ? lo : (i == 3) ? hi : r[31:24];
			wr(5'h03, {r[0], 7'h0D}, 2'b00);
			wr(5'h05, b, 2'b00);
			wr(5'h06, lo, 2'b00);
			wr(5'h07, hi, 2'b00);
			cyc(4);
			pin("freq", fexp(b, lo, hi, r[0]), {6'h00, boost_freq});
			pin("half duty", {7'h00, fexp(b, lo, hi, r[0]) == 8'h00}, {7'h00, max_duty_half});
		end
		wr(5'h05, 8'h10, 2'b00);
		wr(5'h06, 8'h40, 2'b00);
		cyc(450);
		wr(5'h06, 8'h00, 2'b00);
		wr(5'h07, 8'h00, 2'b00);
		wr(5'h03, 8'h8D, 2'b00);
		trip_req <= 1'b1;
		cyc(600);
		trip_req <= 1'b0;
		cyc(4);
		rd(5'h0F, 10'h001);
		rd(5'h0F, 10'h000);
		for (i = 0; i < 2; i++) begin
			wr(5'h10, 8'(i), 2'b00);
			short_mask <= 4'h2;
			cyc(30);
			pin("sinks short", i ? 8'h0D : 8'h0F, {4'h0, sink_enable});
			short_mask <= 4'h0;
			rd(5'h0F, 10'h004);
			wr(5'h08, 8'h0F, 2'b00);
			wr(5'h08, 8'h1F, 2'b00);
		end
		open_mask <= 4'h1;
		cyc(10);
		pin("sinks open", 8'h0F, {4'h0, sink_enable});
		open_mask <= 4'h0;
		for (i = 0; i < 200 && boost_gate !== 1'b1; i++) @(posedge aclk);
		pin("resume", 8'h01, {7'h00, boost_gate});
		rd(5'h0F, 10'h002);
		wr(5'h02, 8'h2A, 2'b00);
		open_mask <= 4'h1;
		cyc(10);
		pin("sinks open", 8'h0E, {4'h0, sink_enable});
		open_mask <= 4'h0;
		cyc(10);
		pin("sinks reconnect", 8'h0E, {4'h0, sink_enable});
		rd(5'h0F, 10'h002);
		wr(5'h08, 8'h0F, 2'b00);
		wr(5'h08, 8'h1F, 2'b00);
		cyc(4);
		pin("sinks restart", 8'h0F, {4'h0, sink_enable});
		open_mask <= 4'hF;
		cyc(10);
		open_mask <= 4'h0;
		cyc(100);
		pin("all open", 8'h00, {3'h0, boost_gate, sink_enable});
		hardware_enable_pin <= 1'b0;
		cyc(4);
		hardware_enable_pin <= 1'b1;
		cyc(6);
		wr(5'h08, 8'h1F, 2'b00);
		cyc(4);
		pin("sinks hardware_enable_pin", 8'h0F, {4'h0, sink_enable});
		pin("rails", 8'h03, rails);
		wr(5'h09, 8'h9C, 2'b00);
		cyc(4);
		pin("rails", 8'h09, rails);
		wr(5'h09, 8'h81, 2'b00);
		for (i = 0; i < 4; i++) begin
			{pos_rail_enable_pin, neg_rail_enable_pin} <= 2'(i);
			cyc(5);
			pin("rails pins", {4'h0, 2'(i), 2'b00}, rails);
		end
		wr(5'h0D, 8'h10, 2'b00);
		wr(5'h0C, 8'h20, 2'b00);
		cyc(4);
		pin("pos level", 8'h1E, {2'b00, bias.pos_level});
		pin("boost level", 8'h20, {2'b00, bias.boost_level});
		wr(5'h09, 8'h81, 2'b00);
		wr(5'h0C, 8'h3F, 2'b00);
		cyc(4);
		pin("pos level", 8'h10, {2'b00, bias.pos_level});
		pin("boost clamp", 8'h34, {2'b00, bias.boost_level});
		overload_req <= 1'b1;
		cyc(10);
		overload_req <= 1'b0;
		pin("rails flag only", 8'h0C, rails);
		cyc(4);
		rd(5'h0F, 10'h008);
		rd(5'h0F, 10'h000);
		wr(5'h0B, 8'h0C, 2'b00);
		wr(5'h0A, 8'h40, 2'b00);
		overload_req <= 1'b1;
		cyc(8);
		overload_req <= 1'b0;
		cyc(4);
		pin("rails filtered", 8'h0C, rails);
		overload_req <= 1'b1;
		cyc(30);
		pin("rails shut", 8'h00, rails);
		overload_req <= 1'b0;
		wr(5'h08, 8'h80, 2'b00);
		cyc(2);
		wr(5'h09, 8'h81, 2'b00);
		wr(5'h08, 8'h1F, 2'b00);
		wr(5'h0A, 8'h80, 2'b00);
		overload_req <= 1'b1;
		cyc(20);
		pin("all shut", 8'h00, {rails[3:0], sink_enable});
		overload_req <= 1'b0;
		cyc(4);
		wrap_up();
	end
endmodule
`default_nettype wire

// file: core/bbp_ctrl.sv
`include "bbp_defines.svh"
`default_nettype none
module bbp_ctrl #(
	parameter int ADDR_W = 12,
	parameter int MAX_DUTY_PCT = 90,
	parameter int SHORT_QUAL_CYC = `BBP_SHORT_QUAL_MS * (`BBP_CLK_HZ / 1000),
	parameter int FILT0_CYC = `BBP_FILT0_US * (`BBP_CLK_HZ / 1000000),
	parameter int FILT1_CYC = `BBP_FILT1_US * (`BBP_CLK_HZ / 1000000),
	parameter int FILT2_CYC = `BBP_FILT2_US * (`BBP_CLK_HZ / 1000000),
	parameter int FILT3_CYC = `BBP_FILT3_US * (`BBP_CLK_HZ / 1000000)
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// pins
	input wire logic hardware_enable_pin,
	input wire logic pos_rail_enable_pin,
	input wire logic neg_rail_enable_pin,
	// power stage sense
	input wire bbp_pkg::bbp_stage_t stage,
	// power stage control
	output logic [3:0] sink_enable,
	output logic boost_gate,
	output bbp_pkg::bbp_freq_t boost_freq,
	output logic max_duty_half,
	output logic [1:0] current_limit_sel,
	output bbp_pkg::bbp_bias_t bias
);
	localparam int QW = 22;
	localparam logic [7:0] ON_MID = 8'(`BBP_PER_500K * MAX_DUTY_PCT / 100);
	localparam logic [7:0] ON_HIGH = 8'(`BBP_PER_1M * MAX_DUTY_PCT / 100);

	if (ADDR_W < 8 || MAX_DUTY_PCT < 1 || MAX_DUTY_PCT > 100) begin : g_chk_a
		$error("bbp_ctrl: bad address width or duty limit");
	end
	if (SHORT_QUAL_CYC < 1 || SHORT_QUAL_CYC >= 2**QW || FILT0_CYC < 1 || FILT3_CYC >= 2**QW) begin : g_chk_b
		$error("bbp_ctrl: qualification count out of range");
	end

	function automatic logic [4:0] reg_idx(input logic [ADDR_W-1:0] a);
		reg_idx = a[6:2];
	endfunction

	function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
		logic [4:0] i;
		i = a[6:2];
		reg_mapped = (a[1:0] == 2'b00) && (a[ADDR_W-1:7] == '0) && (i >= `BBP_R_BL_CFG_ONE)
			&& (i <= `BBP_R_CUR_LIMIT) && (i != 5'h04);
	endfunction

	function automatic logic [7:0] reg_default(input logic [4:0] i);
		case (i)
			`BBP_R_BL_CFG_ONE: reg_default = `BBP_RST_BL_CFG_ONE;
			`BBP_R_BL_CFG_TWO: reg_default = `BBP_RST_BL_CFG_TWO;
			`BBP_R_BRIGHT: reg_default = `BBP_RST_BRIGHT;
			`BBP_R_BIAS_EN: reg_default = `BBP_RST_BIAS_EN;
			`BBP_R_SHORT_RESP: reg_default = `BBP_RST_SHORT_RESP;
			`BBP_R_BOOST_LVL, `BBP_R_POS_LVL, `BBP_R_NEG_LVL: reg_default = `BBP_RST_LEVEL;
			default: reg_default = `BBP_RST_ZERO;
		endcase
	endfunction

	function automatic logic [5:0] level_clamp(input logic [7:0] v, input logic [5:0] top);
		level_clamp = (v[7:6] != 2'b00 || v[`BBP_LEVEL_FIELD] > top) ? top : v[`BBP_LEVEL_FIELD];
	endfunction

	// pin synchronisers
	logic [13:0] sync1;
	logic [13:0] sync2;
	bbp_pkg::bbp_stage_t st;
	logic hw_en;
	logic pin_p;
	logic pin_n;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1 <= 14'h0000;
			sync2 <= 14'h0000;
		end else begin
			sync1 <= {hardware_enable_pin, pos_rail_enable_pin, neg_rail_enable_pin, stage};
			sync2 <= sync1;
		end
	end

	assign hw_en = sync2[13];
	assign pin_p = sync2[12];
	assign pin_n = sync2[11];
	assign st = sync2[10:0];

	// register bus
	logic aw_got;
	logic w_got;
	logic [ADDR_W-1:0] aw_q;
	logic [7:0] wd_q;
	logic ws_q;
	logic do_write;
	logic rd_fault;
	logic soft_pend;
	logic clr;
	logic [7:0] cfg [`BBP_R_BL_CFG_ONE:`BBP_R_CUR_LIMIT];
	logic [7:0] fault;
	logic wr_bias;

	assign do_write = aw_got && w_got && !bvalid;
	assign clr = !aresetn || !hw_en || soft_pend;
	assign rd_fault = arvalid && arready && reg_mapped(araddr) && (reg_idx(araddr) == `BBP_R_FAULT);
	assign wr_bias = do_write && hw_en && ws_q && reg_mapped(aw_q) && (reg_idx(aw_q) == `BBP_R_BIAS_EN);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got <= 1'b0;
			awready <= 1'b0;
			aw_q <= '0;
		end else if (awvalid && awready) begin
			aw_got <= 1'b1;
			awready <= 1'b0;
			aw_q <= awaddr;
		end else if (do_write) begin
			aw_got <= 1'b0;
		end else if (!aw_got && !bvalid) begin
			awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_got <= 1'b0;
			wready <= 1'b0;
			wd_q <= 8'h00;
			ws_q <= 1'b0;
		end else if (wvalid && wready) begin
			w_got <= 1'b1;
			wready <= 1'b0;
			wd_q <= wdata[7:0];
			ws_q <= wstrb[0];
		end else if (do_write) begin
			w_got <= 1'b0;
		end else if (!w_got && !bvalid) begin
			wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= 2'b00;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp <= reg_mapped(aw_q) ? 2'b00 : 2'b10;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= 2'b00;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rresp <= reg_mapped(araddr) ? 2'b00 : 2'b10;
			if (!reg_mapped(araddr)) begin
				rdata <= 32'h00000000;
			end else if (reg_idx(araddr) == `BBP_R_FAULT) begin
				rdata <= {24'h000000, fault};
			end else begin
				rdata <= {24'h000000, cfg[reg_idx(araddr)]};
			end
		end else if (rvalid) begin
			rvalid <= !rready;
		end else begin
			arready <= 1'b1;
		end
	end

	// soft clear lasts one cycle, the bit itself is never stored
	always_ff @(posedge aclk) begin
		if (clr) begin
			soft_pend <= 1'b0;
		end else begin
			soft_pend <= do_write && ws_q && reg_mapped(aw_q) && reg_idx(aw_q) == `BBP_R_BL_ENABLE
				&& wd_q[`BBP_SOFT_CLEAR_BIT];
		end
	end

	always_ff @(posedge aclk) begin
		if (clr) begin
			for (int i = `BBP_R_BL_CFG_ONE; i <= `BBP_R_CUR_LIMIT; i++) begin
				cfg[i] <= reg_default(5'(i));
			end
		end else if (do_write && hw_en && ws_q && reg_mapped(aw_q) && reg_idx(aw_q) != `BBP_R_FAULT) begin
			if (reg_idx(aw_q) == `BBP_R_BL_ENABLE) begin
				cfg[reg_idx(aw_q)] <= {1'b0, wd_q[6:0]};
			end else begin
				cfg[reg_idx(aw_q)] <= wd_q;
			end
		end
	end

	// backlight restart events
	logic bl_mode;
	logic bl_mode_d;
	logic bl_restart;

	assign bl_mode = cfg[`BBP_R_BL_ENABLE][`BBP_BL_MODE_BIT];
	assign bl_restart = clr || (bl_mode_d && !bl_mode);

	always_ff @(posedge aclk) begin
		if (clr) begin
			bl_mode_d <= 1'b0;
		end else begin
			bl_mode_d <= bl_mode;
		end
	end

	// frequency selection
	logic [7:0] lo_th;
	logic [7:0] hi_th;
	logic [7:0] bright;
	bbp_pkg::bbp_freq_t next_freq;

	assign lo_th = cfg[`BBP_R_FREQ_LO];
	assign hi_th = cfg[`BBP_R_FREQ_HI];
	assign bright = cfg[`BBP_R_BRIGHT];

	always_comb begin
		if (lo_th != 8'h00 || hi_th != 8'h00) begin
			if (bright <= lo_th) begin
				next_freq = bbp_pkg::BBP_F250K;
			end else if (bright <= hi_th) begin
				next_freq = bbp_pkg::BBP_F500K;
			end else begin
				next_freq = bbp_pkg::BBP_F1M;
			end
		end else if (cfg[`BBP_R_BL_CFG_TWO][`BBP_FIXED_FREQ_BIT]) begin
			next_freq = bbp_pkg::BBP_F1M;
		end else begin
			next_freq = bbp_pkg::BBP_F500K;
		end
	end

	always_ff @(posedge aclk) begin
		if (clr) begin
			boost_freq <= bbp_pkg::BBP_F500K;
			max_duty_half <= 1'b0;
			current_limit_sel <= 2'b00;
		end else begin
			boost_freq <= next_freq;
			max_duty_half <= (next_freq == bbp_pkg::BBP_F250K);
			current_limit_sel <= cfg[`BBP_R_CUR_LIMIT][`BBP_CUR_LIMIT_FIELD];
		end
	end

	// sink short qualification
	logic [3:0] short_hit;
	logic [3:0] short_off;
	logic [3:0] open_off;
	logic all_open;
	logic [3:0] ch_en;
	logic open_mode;

	assign ch_en = cfg[`BBP_R_BL_ENABLE][`BBP_SINK_EN_FIELD];
	assign open_mode = cfg[`BBP_R_BL_CFG_ONE][`BBP_OPEN_MODE_BIT];

	for (genvar i = 0; i < 4; i++) begin : g_sink
		bbp_qual_filter #(.W(QW)) u_short (
			.aclk(aclk),
			.aresetn(aresetn),
			.clr(clr),
			.cond(st.sink_over_v[i] && sink_enable[i]),
			.limit(QW'(SHORT_QUAL_CYC)),
			.hit(short_hit[i])
		);
	end

	always_ff @(posedge aclk) begin
		if (bl_restart) begin
			short_off <= 4'h0;
		end else if (cfg[`BBP_R_SINK_FAULT][`BBP_SHORT_MODE_BIT]) begin
			short_off <= short_off | short_hit;
		end
	end

	// open string handling on overvoltage
	always_ff @(posedge aclk) begin
		if (bl_restart) begin
			open_off <= 4'h0;
			all_open <= 1'b0;
		end else if (st.boost_overvoltage && ch_en != 4'h0 && bl_mode) begin
			if ((ch_en & ~st.sink_low_headroom) == 4'h0) begin
				all_open <= 1'b1;
			end else if (open_mode) begin
				open_off <= open_off | (ch_en & st.sink_low_headroom);
			end
		end
	end

	// overcurrent event count
	logic trip_d;
	logic [3:0] oc_cnt;

	always_ff @(posedge aclk) begin
		if (clr) begin
			trip_d <= 1'b0;
			oc_cnt <= 4'h0;
		end else begin
			trip_d <= st.current_trip;
			if (rd_fault) begin
				oc_cnt <= {3'b000, st.current_trip && !trip_d};
			end else if (st.current_trip && !trip_d && oc_cnt != `BBP_OC_EVENTS) begin
				oc_cnt <= oc_cnt + 4'h1;
			end
		end
	end

	// positive rail short filter and response
	logic [QW-1:0] filt_lim;
	logic rail_hit;
	logic rail_off;
	logic bl_off;

	always_comb begin
		case (cfg[`BBP_R_SHORT_FILT][`BBP_FILT_FIELD])
			2'b00: filt_lim = QW'(FILT0_CYC);
			2'b01: filt_lim = QW'(FILT1_CYC);
			2'b10: filt_lim = QW'(FILT2_CYC);
			default: filt_lim = QW'(FILT3_CYC);
		endcase
	end

	bbp_qual_filter #(.W(QW)) u_rail (
		.aclk(aclk),
		.aresetn(aresetn),
		.clr(clr),
		.cond(st.pos_rail_overload && bias.pos_on),
		.limit(filt_lim),
		.hit(rail_hit)
	);

	always_ff @(posedge aclk) begin
		if (clr) begin
			rail_off <= 1'b0;
			bl_off <= 1'b0;
		end else if (rail_hit && cfg[`BBP_R_SHORT_RESP][`BBP_RESP_FIELD] != 2'b00) begin
			rail_off <= 1'b1;
			bl_off <= bl_off || cfg[`BBP_R_SHORT_RESP][7];
		end
	end

	// fault status, set wins over clear on read
	logic boost_run_en;
	logic [7:0] flt_set;

	// overcurrent flag is set by the trip that reaches the terminal count, so a read clears it
	always_comb begin
		flt_set = 8'h00;
		flt_set[`BBP_FLT_OC] = st.current_trip && !trip_d && (oc_cnt == `BBP_OC_EVENTS - 4'h1);
		flt_set[`BBP_FLT_OV] = st.boost_overvoltage && boost_run_en;
		flt_set[`BBP_FLT_SHORT] = |short_hit;
		flt_set[`BBP_FLT_RAIL] = st.pos_rail_overload && bias.pos_on;
	end

	always_ff @(posedge aclk) begin
		if (clr) begin
			fault <= 8'h00;
		end else begin
			fault <= flt_set | (fault & {8{!rd_fault}});
		end
	end

	// backlight outputs
	logic [3:0] next_sink;
	logic [7:0] period;
	logic [7:0] on_len;

	assign next_sink = {4{bl_mode && !all_open && !bl_off}} & ch_en & ~short_off & ~open_off;
	assign boost_run_en = hw_en && bl_mode && !all_open && !bl_off && (next_sink != 4'h0);

	always_ff @(posedge aclk) begin
		if (clr) begin
			sink_enable <= 4'h0;
		end else begin
			sink_enable <= next_sink;
		end
	end

	always_comb begin
		case (boost_freq)
			bbp_pkg::BBP_F250K: begin
				period = 8'(`BBP_PER_250K);
				on_len = 8'(`BBP_PER_250K / 2);
			end
			bbp_pkg::BBP_F1M: begin
				period = 8'(`BBP_PER_1M);
				on_len = ON_HIGH;
			end
			default: begin
				period = 8'(`BBP_PER_500K);
				on_len = ON_MID;
			end
		endcase
	end

	bbp_switch_cycle u_cycle (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(boost_run_en && !st.boost_overvoltage),
		.period(period),
		.on_len(on_len),
		.trip(st.current_trip),
		.gate(boost_gate)
	);

	// bias rails
	logic [7:0] ben;
	logic next_pos_on;
	logic next_neg_on;

	assign ben = cfg[`BBP_R_BIAS_EN];
	assign next_pos_on = ben[`BBP_BIAS_MODE_BIT] && !rail_off
		&& (ben[`BBP_PIN_CTRL_BIT] ? pin_p : ben[`BBP_POS_EN_BIT]);
	assign next_neg_on = ben[`BBP_BIAS_MODE_BIT] && !rail_off
		&& (ben[`BBP_PIN_CTRL_BIT] ? pin_n : ben[`BBP_NEG_EN_BIT]);

	always_ff @(posedge aclk) begin
		if (clr) begin
			bias <= '0;
		end else begin
			bias.boost_level <= level_clamp(cfg[`BBP_R_BOOST_LVL], `BBP_BOOST_MAX);
			if (wr_bias || (!bias.pos_on && !bias.neg_on)) begin
				bias.pos_level <= level_clamp(cfg[`BBP_R_POS_LVL], `BBP_RAIL_MAX);
				bias.neg_level <= level_clamp(cfg[`BBP_R_NEG_LVL], `BBP_RAIL_MAX);
			end
			bias.pos_on <= next_pos_on;
			bias.neg_on <= next_neg_on;
			bias.pos_discharge <= ben[`BBP_POS_DIS_BIT] && !next_pos_on;
			bias.neg_discharge <= ben[`BBP_NEG_DIS_BIT] && !next_neg_on;
		end
	end
endmodule
`default_nettype wire

// file: core/bbp_qual_filter.sv
`default_nettype none
module bbp_qual_filter #(
	parameter int W = 22
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// condition
	input wire logic clr,
	input wire logic cond,
	input wire logic [W-1:0] limit,
	output logic hit
);
	logic [W-1:0] cnt;

	always_ff @(posedge aclk) begin
		if (!aresetn || clr || !cond) begin
			cnt <= '0;
		end else if (cnt != limit) begin
			cnt <= cnt + 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || clr) begin
			hit <= 1'b0;
		end else begin
			hit <= cond && (cnt == limit);
		end
	end
endmodule
`default_nettype wire

// file: core/bbp_switch_cycle.sv
`default_nettype none
module bbp_switch_cycle (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// cycle control
	input wire logic run,
	input wire logic [7:0] period,
	input wire logic [7:0] on_len,
	input wire logic trip,
	output logic gate
);
	logic [7:0] cnt;
	logic tripped;
	logic wrap;
	logic [7:0] next_cnt;

	assign wrap = (cnt >= period - 8'h01);
	assign next_cnt = wrap ? 8'h00 : cnt + 8'h01;

	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			cnt <= 8'h00;
		end else begin
			cnt <= next_cnt;
		end
	end

	// a trip holds the switch off until the next cycle starts
	always_ff @(posedge aclk) begin
		if (!aresetn || !run || wrap) begin
			tripped <= 1'b0;
		end else if (trip) begin
			tripped <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			gate <= 1'b0;
		end else begin
			gate <= (next_cnt < on_len) && !trip && (wrap || !tripped);
		end
	end
endmodule
`default_nettype wire

// file: inc/bbp_defines.svh
`ifndef BBP_DEFINES_SVH
`define BBP_DEFINES_SVH
`define BBP_CLK_HZ 50000000
`define BBP_R_BL_CFG_ONE 5'h02
`define BBP_R_BL_CFG_TWO 5'h03
`define BBP_R_BRIGHT 5'h05
`define BBP_R_FREQ_LO 5'h06
`define BBP_R_FREQ_HI 5'h07
`define BBP_R_BL_ENABLE 5'h08
`define BBP_R_BIAS_EN 5'h09
`define BBP_R_SHORT_RESP 5'h0A
`define BBP_R_SHORT_FILT 5'h0B
`define BBP_R_BOOST_LVL 5'h0C
`define BBP_R_POS_LVL 5'h0D
`define BBP_R_NEG_LVL 5'h0E
`define BBP_R_FAULT 5'h0F
`define BBP_R_SINK_FAULT 5'h10
`define BBP_R_CUR_LIMIT 5'h11
`define BBP_RST_BL_CFG_ONE 8'h28
`define BBP_RST_BL_CFG_TWO 8'h8D
`define BBP_RST_BRIGHT 8'hFF
`define BBP_RST_BIAS_EN 8'h18
`define BBP_RST_SHORT_RESP 8'h11
`define BBP_RST_LEVEL 8'h1E
`define BBP_RST_ZERO 8'h00
`define BBP_OPEN_MODE_BIT 1
`define BBP_FIXED_FREQ_BIT 7
`define BBP_SOFT_CLEAR_BIT 7
`define BBP_BL_MODE_BIT 4
`define BBP_SINK_EN_FIELD 3:0
`define BBP_SHORT_MODE_BIT 0
`define BBP_BIAS_MODE_BIT 7
`define BBP_POS_DIS_BIT 4
`define BBP_NEG_DIS_BIT 3
`define BBP_POS_EN_BIT 2
`define BBP_NEG_EN_BIT 1
`define BBP_PIN_CTRL_BIT 0
`define BBP_CUR_LIMIT_FIELD 1:0
`define BBP_RESP_FIELD 7:6
`define BBP_FILT_FIELD 3:2
`define BBP_LEVEL_FIELD 5:0
`define BBP_FLT_OC 0
`define BBP_FLT_OV 1
`define BBP_FLT_SHORT 2
`define BBP_FLT_RAIL 3
`define BBP_SHORT_QUAL_MS 59
`define BBP_FILT0_US 100
`define BBP_FILT1_US 500
`define BBP_FILT2_US 1000
`define BBP_FILT3_US 2000
`define BBP_PER_250K (`BBP_CLK_HZ / 250000)
`define BBP_PER_500K (`BBP_CLK_HZ / 500000)
`define BBP_PER_1M (`BBP_CLK_HZ / 1000000)
`define BBP_BOOST_MAX 6'h34
`define BBP_RAIL_MAX 6'h2E
`define BBP_OC_EVENTS 4'h8
`endif

// file: inc/bbp_pkg.sv
`default_nettype none
package bbp_pkg;
	typedef enum logic [1:0] {BBP_F250K, BBP_F500K, BBP_F1M} bbp_freq_t;
	typedef struct packed {
		logic [3:0] sink_over_v;
		logic [3:0] sink_low_headroom;
		logic boost_overvoltage;
		logic current_trip;
		logic pos_rail_overload;
	} bbp_stage_t;
	typedef struct packed {
		logic [5:0] boost_level;
		logic [5:0] pos_level;
		logic [5:0] neg_level;
		logic pos_on;
		logic neg_on;
		logic pos_discharge;
		logic neg_discharge;
	} bbp_bias_t;
endpackage
`default_nettype wire
